/* hdl/sbsc_params.svh */
`ifndef SBSC_PARAMS_SVH
`define SBSC_PARAMS_SVH
// Cycles to enter or leave sleep
`define SBSC_SLEEP_CYCLES 2
`define SBSC_ADDR_WIDTH 18
`define SBSC_LANES 4
`define SBSC_BURST_LO 1
`define SBSC_RST_ADDR 18'h00000
`define SBSC_RST_CNT 2'h0
`endif

/* hdl/sbsc_pkg.sv */
package sbsc_pkg;
  typedef enum logic [2:0] {
    SBSC_DESEL,
    SBSC_READ,
    SBSC_WRITE,
    SBSC_SLEEP
  } sbsc_cycle_t;
  typedef enum logic [1:0] {
    SBSC_AWAKE,
    SBSC_ENTERING,
    SBSC_ASLEEP,
    SBSC_LEAVING
  } sbsc_pwr_t;
endpackage

/* hdl/sbsc_burst_step.sv */
`timescale 1ns/1ps
`include "sbsc_params.svh"
// Next two-bit burst address from the start address and the step count
module sbsc_burst_step (
  input wire logic [1:0] start_lo,
  input wire logic [1:0] count,
  input wire logic interleave,
  output logic [1:0] addr_lo
);
  always_comb begin
    if (interleave) begin
      addr_lo = start_lo ^ count;
    end else begin
      addr_lo = 2'(start_lo + count);
    end
  end
endmodule

/* hdl/sbsc_lane_decode.sv */
`timescale 1ns/1ps
`include "sbsc_params.svh"
// Active-high per-lane write strobes from the write qualifiers
module sbsc_lane_decode #(
  parameter int LANES = `SBSC_LANES
) (
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic [LANES-1:0] byte_lane_select_n,
  output logic [LANES-1:0] lane_we,
  output logic write_any
);
  genvar i;
  generate
    for (i = 0; i < LANES; i++) begin : g_lane
      assign lane_we[i] = !global_write_n ||
        (!byte_write_enable_n && !byte_lane_select_n[i]);
    end
  endgenerate
  assign write_any = |lane_we;
endmodule

/* hdl/sbsc_cycle_decode.sv */
`timescale 1ns/1ps
`include "sbsc_params.svh"
module sbsc_cycle_decode #(
  parameter int AW = `SBSC_ADDR_WIDTH,
  parameter int LANES = `SBSC_LANES
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic CHIP_SELECT_PRIMARY_N,
  input wire logic CHIP_SELECT_SECOND,
  input wire logic CHIP_SELECT_THIRD_N,
  input wire logic PROCESSOR_ADDR_STROBE_N,
  input wire logic CONTROLLER_ADDR_STROBE_N,
  input wire logic BURST_STEP_N,
  input wire logic GLOBAL_WRITE_N,
  input wire logic BYTE_WRITE_ENABLE_N,
  input wire logic [LANES-1:0] BYTE_LANE_SELECT_N,
  input wire logic BURST_ORDER,
  input wire logic SLEEP_REQUEST,
  input wire logic [AW-1:0] ADDR,
  output logic [AW-1:0] MEM_ADDR,
  output logic [LANES-1:0] MEM_LANE_WE,
  output logic MEM_READ,
  output logic READ_CYCLE,
  output logic WRITE_CYCLE,
  output logic ASLEEP
);
  // Output enable is combinational downstream of READ_CYCLE; the pad
  // driver computes pad_en = READ_CYCLE & ~oe_n with no clocking.

  typedef struct packed {
    logic [AW-1:0] base;
    logic [1:0] cnt;
    logic [AW-1:0] mem_addr;
    logic [LANES-1:0] lane_we;
    logic mem_read;
    logic rd;
    logic wr;
    logic asleep;
    logic [1:0] pwr_cnt;
    sbsc_pkg::sbsc_pwr_t pwr;
  } sbsc_state_t;

  sbsc_state_t state_reg;
  sbsc_state_t state_next;

  logic [LANES-1:0] lane_we;
  logic write_any;
  logic [1:0] step_lo;
  logic [1:0] cnt_inc;
  logic [1:0] start_lo;

  sbsc_lane_decode #(.LANES(LANES)) u_lane (
    .global_write_n(GLOBAL_WRITE_N),
    .byte_write_enable_n(BYTE_WRITE_ENABLE_N),
    .byte_lane_select_n(BYTE_LANE_SELECT_N),
    .lane_we(lane_we),
    .write_any(write_any)
  );

  assign cnt_inc = 2'(state_reg.cnt + 2'h1);
  assign start_lo = state_reg.base[`SBSC_BURST_LO:0];

  sbsc_burst_step u_step (
    .start_lo(start_lo),
    .count(cnt_inc),
    .interleave(BURST_ORDER),
    .addr_lo(step_lo)
  );

  function automatic logic selected(input logic primary_n,
                                    input logic second,
                                    input logic third_n);
    selected = !primary_n && second && !third_n;
  endfunction

  // ==========================================================
  // Cycle decode
  logic sel;
  logic proc_strobe;
  logic ctrl_strobe;
  logic sleep_hold;
  always_comb begin
    sel = selected(CHIP_SELECT_PRIMARY_N, CHIP_SELECT_SECOND,
                   CHIP_SELECT_THIRD_N);
    // Processor strobe counts only when primary select is low
    proc_strobe = !PROCESSOR_ADDR_STROBE_N && !CHIP_SELECT_PRIMARY_N;
    ctrl_strobe = !CONTROLLER_ADDR_STROBE_N;
    state_next = state_reg;
    state_next.lane_we = '0;
    state_next.mem_read = 1'b0;
    state_next.rd = 1'b0;
    state_next.wr = 1'b0;

    // ==========================================================
    // Sleep sequencing
    case (state_reg.pwr)
      sbsc_pkg::SBSC_AWAKE: begin
        if (SLEEP_REQUEST) begin
          state_next.pwr = sbsc_pkg::SBSC_ENTERING;
          state_next.pwr_cnt = 2'h1;
        end
      end
      sbsc_pkg::SBSC_ENTERING: begin
        if (!SLEEP_REQUEST) begin
          state_next.pwr = sbsc_pkg::SBSC_AWAKE;
        end else if (state_reg.pwr_cnt == 2'(`SBSC_SLEEP_CYCLES - 1)) begin
          state_next.pwr = sbsc_pkg::SBSC_ASLEEP;
          state_next.asleep = 1'b1;
        end else begin
          state_next.pwr_cnt = 2'(state_reg.pwr_cnt + 2'h1);
        end
      end
      sbsc_pkg::SBSC_ASLEEP: begin
        if (!SLEEP_REQUEST) begin
          state_next.pwr = sbsc_pkg::SBSC_LEAVING;
          state_next.pwr_cnt = 2'h1;
        end
      end
      sbsc_pkg::SBSC_LEAVING: begin
        if (SLEEP_REQUEST) begin
          state_next.pwr = sbsc_pkg::SBSC_ASLEEP;
        end else if (state_reg.pwr_cnt == 2'(`SBSC_SLEEP_CYCLES - 1)) begin
          state_next.pwr = sbsc_pkg::SBSC_AWAKE;
          state_next.asleep = 1'b0;
        end else begin
          state_next.pwr_cnt = 2'(state_reg.pwr_cnt + 2'h1);
        end
      end
      default: state_next.pwr = sbsc_pkg::SBSC_AWAKE;
    endcase

    // Any sleep request or non-awake state blocks all accesses
    sleep_hold = SLEEP_REQUEST || (state_reg.pwr != sbsc_pkg::SBSC_AWAKE);

    if (sleep_hold) begin
      // Nothing happens: no access, data lines released
      state_next.rd = 1'b0;
    end else if (proc_strobe) begin
      if (sel) begin
        // Read start; write qualifiers ignored here
        state_next.base = ADDR;
        state_next.cnt = `SBSC_RST_CNT;
        state_next.mem_addr = ADDR;
        state_next.mem_read = 1'b1;
        state_next.rd = 1'b1;
      end
      // Otherwise a deselect cycle
    end else if (ctrl_strobe) begin
      if (sel) begin
        state_next.base = ADDR;
        state_next.cnt = `SBSC_RST_CNT;
        state_next.mem_addr = ADDR;
        if (write_any) begin
          state_next.lane_we = lane_we;
          state_next.wr = 1'b1;
        end else begin
          state_next.mem_read = 1'b1;
          state_next.rd = 1'b1;
        end
      end
      // Primary select high or second/third inactive: deselect
    end else begin
      if (!BURST_STEP_N) begin
        state_next.cnt = cnt_inc;
        state_next.mem_addr = {state_reg.base[AW-1:2], step_lo};
      end
      if (write_any) begin
        state_next.lane_we = lane_we;
        state_next.wr = 1'b1;
      end else begin
        state_next.mem_read = 1'b1;
        state_next.rd = 1'b1;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= '{base: `SBSC_RST_ADDR, cnt: `SBSC_RST_CNT,
                     mem_addr: `SBSC_RST_ADDR, lane_we: '0,
                     mem_read: 1'b0, rd: 1'b0, wr: 1'b0, asleep: 1'b0,
                     pwr_cnt: 2'h0, pwr: sbsc_pkg::SBSC_AWAKE};
    end else begin
      state_reg <= state_next;
    end
  end

  assign MEM_ADDR = state_reg.mem_addr;
  assign MEM_LANE_WE = state_reg.lane_we;
  assign MEM_READ = state_reg.mem_read;
  // Drive enable for data lines gated by write and sleep
  assign READ_CYCLE = state_reg.rd;
  assign WRITE_CYCLE = state_reg.wr;
  assign ASLEEP = state_reg.asleep;

  // ==========================================================
  // Checks
  // Each property except a_write_masks judges a decision one edge after its inputs were taken
  sequence s_start_read;
    !SLEEP_REQUEST && state_reg.pwr == sbsc_pkg::SBSC_AWAKE &&
      !PROCESSOR_ADDR_STROBE_N && sel;
  endsequence

  sequence s_sleep_two;
    (state_reg.pwr == sbsc_pkg::SBSC_AWAKE && SLEEP_REQUEST) ##1
      SLEEP_REQUEST;
  endsequence

  sequence s_wake_two;
    (state_reg.pwr == sbsc_pkg::SBSC_ASLEEP && !SLEEP_REQUEST) ##1
      !SLEEP_REQUEST;
  endsequence

  a_proc_read_only: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    s_start_read |=> READ_CYCLE && !WRITE_CYCLE && MEM_LANE_WE == '0
      && MEM_ADDR == $past(ADDR))
    else $error("processor strobe start not a plain read");
  a_no_proc_write: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    (!PROCESSOR_ADDR_STROBE_N && !CHIP_SELECT_PRIMARY_N) |=> !WRITE_CYCLE)
    else $error("write in processor strobe cycle");
  a_write_qual: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    (!sleep_hold && !proc_strobe && !ctrl_strobe)
      |=> WRITE_CYCLE == (!$past(GLOBAL_WRITE_N) ||
        (!$past(BYTE_WRITE_ENABLE_N) && $past(BYTE_LANE_SELECT_N) != '1)))
    else $error("write qualifier decoded wrongly");
  a_ctrl_write: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    (!sleep_hold && PROCESSOR_ADDR_STROBE_N && ctrl_strobe && sel &&
      write_any)
      |=> WRITE_CYCLE && MEM_LANE_WE == $past(lane_we))
    else $error("controller write start missed");
  a_ctrl_read: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    (!sleep_hold && PROCESSOR_ADDR_STROBE_N && ctrl_strobe && sel &&
      !write_any)
      |=> READ_CYCLE && MEM_ADDR == $past(ADDR))
    else $error("controller read start missed");
  a_burst_next: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    (!sleep_hold && !proc_strobe && !ctrl_strobe && !BURST_STEP_N)
      |=> state_reg.cnt == 2'($past(state_reg.cnt) + 2'h1)
      && (READ_CYCLE || WRITE_CYCLE))
    else $error("burst did not advance");
  a_burst_hold: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    (!sleep_hold && !proc_strobe && !ctrl_strobe && BURST_STEP_N)
      |=> $stable(state_reg.cnt) && $stable(MEM_ADDR))
    else $error("suspended burst moved");
  a_burst_order: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    (!sleep_hold && !proc_strobe && !ctrl_strobe && !BURST_STEP_N)
      |=> MEM_ADDR[1:0] == ($past(BURST_ORDER) ?
        (state_reg.base[1:0] ^ state_reg.cnt) :
        2'(state_reg.base[1:0] + state_reg.cnt)))
    else $error("burst address out of order");
  a_desel_quiet: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    (CHIP_SELECT_PRIMARY_N && ctrl_strobe) |=> !READ_CYCLE && !WRITE_CYCLE)
    else $error("deselect cycle accessed");
  a_desel_select: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    ((proc_strobe || ctrl_strobe) &&
      (!CHIP_SELECT_SECOND || CHIP_SELECT_THIRD_N))
      |=> !READ_CYCLE && !WRITE_CYCLE)
    else $error("deselected strobe cycle accessed");
  a_lane_select: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    (!sleep_hold && !proc_strobe && !ctrl_strobe && GLOBAL_WRITE_N &&
      !BYTE_WRITE_ENABLE_N) |=> MEM_LANE_WE == ~$past(BYTE_LANE_SELECT_N))
    else $error("byte lanes written wrongly");
  a_write_masks: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    WRITE_CYCLE |-> !READ_CYCLE && !MEM_READ)
    else $error("drive enable during write");
  a_sleep_quiet: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    SLEEP_REQUEST |=> !READ_CYCLE && !WRITE_CYCLE)
    else $error("access during sleep");
  a_sleep_entry: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    s_sleep_two |=> ASLEEP)
    else $error("sleep not entered in two cycles");
  a_sleep_exit: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    s_wake_two |=> !ASLEEP)
    else $error("sleep not left in two cycles");
  a_wake_quiet: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    (state_reg.pwr == sbsc_pkg::SBSC_LEAVING) |=> !READ_CYCLE && !WRITE_CYCLE)
    else $error("access during sleep recovery");
  a_upper_hold: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    (!sleep_hold && !proc_strobe && !ctrl_strobe)
      |=> MEM_ADDR[AW-1:2] == $past(state_reg.base[AW-1:2]))
    else $error("upper address changed in burst");
endmodule

/* tb/sbsc_host_model.sv */
`timescale 1ns/1ps
// ====
// Bus master: a request changes after an edge and stands one cycle
module sbsc_host_model (
  input wire logic clk,
  output logic chip_select_primary_n,
  output logic chip_select_second,
  output logic chip_select_third_n,
  output logic processor_addr_strobe_n,
  output logic controller_addr_strobe_n,
  output logic burst_step_n,
  output logic global_write_n,
  output logic byte_write_enable_n,
  output logic [3:0] byte_lane_select_n,
  output logic [17:0] addr,
  output logic burst_order,
  output logic sleep_request,
  output logic oe_n
);
  logic [7:0] ctl;
  assign {chip_select_primary_n, chip_select_second, chip_select_third_n,
          processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n,
          global_write_n, byte_write_enable_n} = ctl;
  initial begin
    ctl = 8'h97;
    byte_lane_select_n = 4'hf;
    addr = 18'h00000;
    burst_order = 1'b0;
    sleep_request = 1'b0;
    oe_n = 1'b1;
  end
  task automatic drive(input logic [7:0] c, input logic [3:0] ln,
                       input logic [17:0] a, input logic md,
                       input logic sl);
    @(posedge clk);
    ctl <= c;
    byte_lane_select_n <= ln;
    addr <= a;
    burst_order <= md;
    sleep_request <= sl;
    // Released before write data may appear; reads try both levels
    oe_n <= (!c[1] || (!c[0] && ln != 4'hf)) ? 1'b1 : 1'($urandom);
  endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic CLOCK, ARST_N, e_rd, e_wr, have, wq, sel;
  logic chip_select_primary_n, chip_select_second, chip_select_third_n;
  logic processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n;
  logic global_write_n, byte_write_enable_n, burst_order, sleep_request;
  logic oe_n, MEM_READ, READ_CYCLE, WRITE_CYCLE, ASLEEP;
  logic [3:0] byte_lane_select_n, MEM_LANE_WE, e_we;
  logic [17:0] addr, MEM_ADDR, m_addr, e_addr, ra;
  logic [1:0] lo;
  logic [31:0] r;
  logic [7:0] dsel [5] = '{8'h97, 8'h07, 8'h6f, 8'h17, 8'h77};
  int num_errors = 0;
  int checks = 0;
  int m_cnt = 0;
  wire pad_en = READ_CYCLE & ~oe_n;
  sbsc_host_model host (.clk(CLOCK), .chip_select_primary_n,
    .chip_select_second, .chip_select_third_n, .processor_addr_strobe_n,
    .controller_addr_strobe_n, .burst_step_n, .global_write_n,
    .byte_write_enable_n, .byte_lane_select_n, .addr, .burst_order,
    .sleep_request, .oe_n);
  sbsc_cycle_decode uut (.CLOCK, .ARST_N,
    .CHIP_SELECT_PRIMARY_N(chip_select_primary_n),
    .CHIP_SELECT_SECOND(chip_select_second),
    .CHIP_SELECT_THIRD_N(chip_select_third_n),
    .PROCESSOR_ADDR_STROBE_N(processor_addr_strobe_n),
    .CONTROLLER_ADDR_STROBE_N(controller_addr_strobe_n),
    .BURST_STEP_N(burst_step_n), .GLOBAL_WRITE_N(global_write_n),
    .BYTE_WRITE_ENABLE_N(byte_write_enable_n),
    .BYTE_LANE_SELECT_N(byte_lane_select_n), .BURST_ORDER(burst_order),
    .SLEEP_REQUEST(sleep_request), .ADDR(addr), .MEM_ADDR,
    .MEM_LANE_WE, .MEM_READ, .READ_CYCLE, .WRITE_CYCLE, .ASLEEP);
  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end
  // ====
  // Checking
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [17:0] rnd();
    logic [31:0] v;
    v = $urandom;
    return v[17:0];
  endfunction
  // ====
  // One request per cycle; the previous one is judged one edge later
  task automatic step(input logic [7:0] c, input logic [3:0] ln,
                      input logic [17:0] a, input logic md,
                      input logic sl);
    host.drive(c, ln, a, md, sl);
    #1;
    if (have) begin
      chk(32'(READ_CYCLE), 32'(e_rd));
      chk(32'(MEM_READ), 32'(e_rd));
      chk(32'(WRITE_CYCLE), 32'(e_wr));
      chk(32'(MEM_LANE_WE), 32'(e_we));
      if (e_rd | e_wr) chk(32'(MEM_ADDR), 32'(e_addr));
      if (e_wr) chk(32'(pad_en), 32'h0);
      chk(32'(pad_en), 32'(e_rd & !oe_n));
    end
    have = 1'b1;
    wq = !c[1] || (!c[0] && ln != 4'hf);
    sel = !c[7] && c[6] && !c[5];
    e_rd = 1'b0;
    e_wr = 1'b0;
    if (!sl && !c[7] && !c[4]) begin
      e_rd = sel;
      if (sel) m_addr = a;
      if (sel) m_cnt = 0;
    end else if (!sl && !c[3]) begin
      e_rd = sel && !wq;
      e_wr = sel && wq;
      if (sel) m_addr = a;
      if (sel) m_cnt = 0;
    end else if (!sl) begin
      if (!c[2]) m_cnt++;
      e_rd = !wq;
      e_wr = wq;
    end
    e_we = !e_wr ? 4'h0 : (!c[1] ? 4'hf : ~ln);
    lo = md ? m_addr[1:0] ^ m_cnt[1:0] : m_addr[1:0] + m_cnt[1:0];
    e_addr = {m_addr[17:2], lo};
  endtask
  initial begin
    #20000;
    num_errors++;
    $display("watchdog expired");
    final_report();
  end
  // ====
  // Tests
  initial begin
    ARST_N = 1'b0;
    have = 1'b0;
    m_addr = 18'h00000;
    void'($urandom(32'h147a));
    repeat (5) @(posedge CLOCK);
    ARST_N <= 1'b1;
    #1;
    chk(32'({READ_CYCLE, WRITE_CYCLE, MEM_READ, MEM_LANE_WE}), 0);
    chk(32'(ASLEEP), 32'h0);
    for (int l = 0; l < 16; l++) begin
      ra = rnd();
      step(8'h56, 4'(l), ra, 1'b0, 1'b0);
      step(8'h9a, 4'(l), ra, 1'b0, 1'b0);
      step(8'h9e, 4'(l), ra, 1'b0, 1'b0);
    end
    step(8'h55, 4'hf, rnd(), 1'b0, 1'b0);
    $display("test lanes done");
    for (int k = 0; k < 8; k++) begin
      ra = rnd();
      ra[1:0] = 2'(k);
      step(8'h4c, 4'h0, ra, k[2], 1'b0);
      step(8'h99, 4'h0, ra, k[2], 1'b0);
      step(8'h9b, 4'h0, ra, k[2], 1'b0);
      step(8'h9f, 4'h0, ra, k[2], 1'b0);
      step(8'h9d, 4'h0, ra, k[2], 1'b0);
      step(8'h9b, 4'h0, ra, k[2], 1'b0);
      step(8'h9b, 4'h0, ra, k[2], 1'b0);
    end
    $display("test bursts done");
    foreach (dsel[i]) step(dsel[i], 4'hf, rnd(), 1'b0, 1'b0);
    for (int i = 0; i < 300; i++) begin
      r = $urandom;
      step(r[7:0], r[11:8], r[29:12], 1'b1, 1'b0);
    end
    $display("test random done");
    // Deselected in the same cycle as the request, so no access is cut short
    step(8'h97, 4'hf, 18'h00000, 1'b0, 1'b1);
    repeat (4) step(8'h4c, 4'hf, rnd(), 1'b0, 1'b1);
    chk(32'(ASLEEP), 32'h1);
    repeat (5) step(8'h97, 4'hf, 18'h00000, 1'b0, 1'b0);
    chk(32'(ASLEEP), 32'h0);
    $display("test sleep done");
    final_report();
  end
endmodule
